//--- hw/wrc_cfg.svh
`ifndef WRC_CFG_SVH
`define WRC_CFG_SVH
// clock rate and counter width
`define WRC_CLK_KHZ       25000
`define WRC_US_PER_MS     1000
`define WRC_CNT_W         24
// timing figures in their own units
`define WRC_T_BIT_US      500
`define WRC_T_BIAS_MS     24
`define WRC_T_DEGL_MS     10
`define WRC_T_MON_PRI_MS  35
`define WRC_T_MON_STD_MS  235
`define WRC_T_ERR_FAST_MS 30
`define WRC_T_ERR_SLOW_MS 250
// character frame
`define WRC_CHAR_BITS     4'hb
`define WRC_BITS_W        4
`define WRC_DATA_BITS     8
`define WRC_START_BIT     1'b0
`define WRC_STOP_BIT      1'b1
// load current levels in mA
`define WRC_I_W           12
`define WRC_ILIM_KNEE_MA  12'h12c
`define WRC_ILIM_FIX_MA   13'h0190
`define WRC_ILIM_ADD_MA   13'h0032
`define WRC_RECT_UP_MA    12'h078
`define WRC_RECT_DN_MA    12'h064
// sensor channels: bit 0 hot, bit 1 cold
`define WRC_TS_CH         2
`endif

//--- hw/wrc_pkg.sv
package wrc_pkg;
  // rectifier operating mode
  typedef enum logic [2:0] {
    RECT_DIODE = 3'h1,
    RECT_HALF  = 3'h2,
    RECT_FULL  = 3'h4
  } wrc_rect_t;
  // temperature sense sequencer phase
  typedef enum logic [1:0] {
    TS_BIAS = 2'h1,
    TS_MON  = 2'h2
  } wrc_ts_t;
endpackage

//--- hw/wrc_biphase.sv
`include "wrc_cfg.svh"
module wrc_biphase #(
  parameter logic [`WRC_CNT_W-1:0] HALF_CYC = `WRC_CNT_W'(
    (`WRC_T_BIT_US * `WRC_CLK_KHZ + 2 * `WRC_US_PER_MS - 1)
    / (2 * `WRC_US_PER_MS))
) (
  // clock and reset
  input  logic clk,
  input  logic rst,
  // bit source
  input  logic bit_valid,
  input  logic bit_val,
  output logic bit_take,
  // modulation state
  output logic active,
  output logic mid,
  output logic cur_bit,
  output logic mod
);
  import wrc_pkg::*;

  logic [`WRC_CNT_W-1:0] cnt;
  logic                  second;
  logic                  half_end;
  logic                  boundary;

  // half-bit timing; an idle modulator starts a bit at once
  assign half_end = active && (cnt == HALF_CYC - 1'b1);
  assign boundary = !active || (half_end && second);
  assign bit_take = boundary && bit_valid;
  assign mid      = half_end && !second;

  // every bit start toggles; a one toggles again at mid-bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= '0;
      second  <= 1'b0;
      active  <= 1'b0;
      cur_bit <= 1'b0;
      mod     <= 1'b0;
    end else begin
      cnt    <= (half_end || !active) ? '0 : cnt + 1'b1;
      second <= bit_take ? 1'b0 : (mid ? 1'b1 : second);
      if (bit_take) begin
        active  <= 1'b1;
        cur_bit <= bit_val;
        mod     <= ~mod;
      end else if (mid && cur_bit) begin
        mod <= ~mod;
      end else if (boundary) begin
        active <= 1'b0; // nothing pending: release load
        mod    <= 1'b0;
      end
    end
  end
endmodule

//--- hw/wrc_deglitch.sv
`include "wrc_cfg.svh"
module wrc_deglitch #(
  parameter logic [`WRC_CNT_W-1:0] CYC = `WRC_CNT_W'(
    `WRC_T_DEGL_MS * `WRC_CLK_KHZ)
) (
  // clock and reset
  input  logic clk,
  input  logic rst,
  // sampled comparator
  input  logic sample_en,
  input  logic raw,
  output logic level
);
  import wrc_pkg::*;

  logic [`WRC_CNT_W-1:0] cnt;
  logic                  run;
  logic                  done;

  // any low sample or closed window restarts the count
  assign run  = sample_en && raw;
  assign done = (cnt == CYC - 1'b1);

  // level rises only after a full steady interval
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt   <= '0;
      level <= 1'b0;
    end else begin
      cnt   <= run ? (done ? cnt : cnt + 1'b1) : '0;
      level <= run && done;
    end
  end
endmodule

//--- hw/wrc_top.sv
`include "wrc_cfg.svh"
module wrc_top #(
  parameter logic [`WRC_CNT_W-1:0] HALF_CYC = `WRC_CNT_W'(
    (`WRC_T_BIT_US * `WRC_CLK_KHZ + 2 * `WRC_US_PER_MS - 1)
    / (2 * `WRC_US_PER_MS)),
  parameter logic [`WRC_CNT_W-1:0] BIAS_CYC = `WRC_CNT_W'(
    `WRC_T_BIAS_MS * `WRC_CLK_KHZ),
  parameter logic [`WRC_CNT_W-1:0] DEGL_CYC = `WRC_CNT_W'(
    `WRC_T_DEGL_MS * `WRC_CLK_KHZ),
  parameter logic [`WRC_CNT_W-1:0] MON_PRI_CYC = `WRC_CNT_W'(
    `WRC_T_MON_PRI_MS * `WRC_CLK_KHZ),
  parameter logic [`WRC_CNT_W-1:0] MON_STD_CYC = `WRC_CNT_W'(
    `WRC_T_MON_STD_MS * `WRC_CLK_KHZ),
  parameter logic [`WRC_CNT_W-1:0] ERR_FAST_CYC = `WRC_CNT_W'(
    `WRC_T_ERR_FAST_MS * `WRC_CLK_KHZ),
  parameter logic [`WRC_CNT_W-1:0] ERR_SLOW_CYC = `WRC_CNT_W'(
    `WRC_T_ERR_SLOW_MS * `WRC_CLK_KHZ)
) (
  // clock and reset
  input  logic                    clk,
  input  logic                    rst,
  // rectifier comparators, asynchronous
  input  logic                    rectified_voltage_above_uvlo,
  input  logic                    rectified_voltage_converged,
  // load current from the on-chip converter, clk domain
  input  logic [`WRC_I_W-1:0]     iout_ma,
  // temperature comparators, asynchronous
  input  logic                    ts_hot,
  input  logic                    ts_cold,
  input  logic                    ts_above_100mv,
  // packet byte source
  input  logic [7:0]              tx_byte,
  input  logic                    tx_valid,
  output logic                    tx_ready,
  // modulator switches
  output logic                    comm_switch_a,
  output logic                    comm_switch_b,
  // supply and open-drain status pin
  output logic                    supply_en,
  output logic                    power_good_n_out,
  output logic                    power_good_oe,
  // regulation controls
  output logic [`WRC_I_W:0]       comm_ilim_ma,
  output wrc_pkg::wrc_rect_t      rect_mode,
  output logic                    err_pkt_due,
  // temperature sense
  output logic                    temp_bias_window,
  output logic                    temp_sense_control_pin_out,
  output logic                    temp_sense_control_pin_oe,
  output logic                    temp_fault,
  output logic                    host_ctrl
);
  import wrc_pkg::*;

  // two-stage synchronisers for the asynchronous comparators
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       uvlo_s;
  logic       conv_s;
  logic       hot_s;
  logic       cold_s;
  logic       ts_hi_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {ts_above_100mv, ts_cold, ts_hot,
                rectified_voltage_converged, rectified_voltage_above_uvlo};
      sync2 <= sync1;
    end
  end

  assign uvlo_s  = sync2[0];
  assign conv_s  = sync2[1];
  assign hot_s   = sync2[2];
  assign cold_s  = sync2[3];
  assign ts_hi_s = sync2[4];

  // character serialiser feeding the biphase modulator
  logic [`WRC_CHAR_BITS-1:0] shreg;
  logic [`WRC_BITS_W-1:0]    bits_left;
  logic [`WRC_BITS_W-1:0]    next_bits_left;
  logic                      load;
  logic                      bit_take;
  logic                      bp_active;
  logic                      bp_mid;
  logic                      bp_bit;
  logic                      bp_mod;
  logic [`WRC_CHAR_BITS-1:0] frame;

  // odd parity over data, start in bit 0 so LSB leaves first
  assign frame = {`WRC_STOP_BIT, ~(^tx_byte), tx_byte,
                  `WRC_START_BIT};
  assign load  = tx_valid && tx_ready;
  assign next_bits_left = load ? `WRC_CHAR_BITS :
                          (bit_take ? bits_left - 1'b1 : bits_left);

  // next byte loads a whole bit before the boundary, so
  // characters of one packet run back to back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg     <= '0;
      bits_left <= '0;
      tx_ready  <= 1'b0;
    end else begin
      if (load) begin
        shreg <= frame;
      end else if (bit_take) begin
        shreg <= shreg >> 1;
      end
      bits_left <= next_bits_left;
      tx_ready  <= (next_bits_left == '0);
    end
  end

  wrc_biphase #(
    .HALF_CYC (HALF_CYC)
  ) u_biphase (
    .clk       (clk),
    .rst       (rst),
    .bit_valid (bits_left != '0),
    .bit_val   (shreg[0]),
    .bit_take  (bit_take),
    .active    (bp_active),
    .mid       (bp_mid),
    .cur_bit   (bp_bit),
    .mod       (bp_mod)
  );

  // both switches carry the same modulation state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comm_switch_a <= 1'b0;
      comm_switch_b <= 1'b0;
    end else begin
      comm_switch_a <= bp_mod;
      comm_switch_b <= bp_mod;
    end
  end

  // supply enable latches on convergence, drops on fault, host control or lockout
  logic next_supply_en;
  assign next_supply_en = uvlo_s && (supply_en || conv_s)
                          && !temp_fault && !host_ctrl;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_en        <= 1'b0;
      power_good_oe    <= 1'b0;
      power_good_n_out <= 1'b0;
    end else begin
      supply_en        <= next_supply_en;
      power_good_oe    <= next_supply_en;
      power_good_n_out <= 1'b0;
    end
  end

  // communication current limit; the knee itself counts as low
  logic              iout_high;
  logic [`WRC_I_W:0] next_ilim;
  assign iout_high = iout_ma > `WRC_ILIM_KNEE_MA;
  assign next_ilim = iout_high ? {1'b0, iout_ma} + `WRC_ILIM_ADD_MA
                               : `WRC_ILIM_FIX_MA;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comm_ilim_ma <= `WRC_ILIM_FIX_MA;
    end else begin
      comm_ilim_ma <= next_ilim;
    end
  end

  // rectifier mode with 120/100 mA hysteresis
  wrc_rect_t next_rect;
  always_comb begin
    next_rect = rect_mode;
    unique case (rect_mode)
      RECT_DIODE: begin
        if (uvlo_s) begin
          next_rect = RECT_HALF;
        end
      end
      RECT_HALF: begin
        if (iout_ma > `WRC_RECT_UP_MA) begin
          next_rect = RECT_FULL;
        end
      end
      RECT_FULL: begin
        if (iout_ma < `WRC_RECT_DN_MA) begin
          next_rect = RECT_HALF;
        end
      end
      default: next_rect = RECT_DIODE;
    endcase
    if (!uvlo_s) begin
      next_rect = RECT_DIODE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rect_mode <= RECT_DIODE;
    end else begin
      rect_mode <= next_rect;
    end
  end

  // error packet cadence; >= lets a shorter period act at once
  logic [`WRC_CNT_W-1:0] err_cnt;
  logic                  err_done;
  assign err_done = err_cnt >=
                    (conv_s ? ERR_SLOW_CYC : ERR_FAST_CYC) - 1'b1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_cnt     <= '0;
      err_pkt_due <= 1'b0;
    end else begin
      err_cnt     <= (err_done || !uvlo_s) ? '0 : err_cnt + 1'b1;
      err_pkt_due <= err_done && uvlo_s;
    end
  end

  // temperature sense sequencer: bias window, then unbiased watch
  wrc_ts_t               ts_state;
  wrc_ts_t               next_ts;
  logic [`WRC_CNT_W-1:0] ts_cnt;
  logic                  bias_end;
  logic                  mon_end;
  logic                  mon_hit;
  logic                  host_seen;
  logic [`WRC_TS_CH-1:0] ts_raw;
  logic [`WRC_TS_CH-1:0] ts_degl;

  // priority period while the rectifier is still converging
  assign bias_end = (ts_state == TS_BIAS)
                    && (ts_cnt == BIAS_CYC - 1'b1);
  assign mon_end  = (ts_state == TS_MON) && (ts_cnt >=
                    (conv_s ? MON_STD_CYC : MON_PRI_CYC) - 1'b1);
  assign mon_hit  = (ts_state == TS_MON) && ts_hi_s;
  assign ts_raw   = {cold_s, hot_s};

  always_comb begin
    next_ts = ts_state;
    unique case (ts_state)
      TS_BIAS: begin
        if (bias_end) begin
          next_ts = TS_MON;
        end
      end
      TS_MON: begin
        if (mon_end) begin
          next_ts = TS_BIAS;
        end
      end
      default: next_ts = TS_BIAS;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_state                   <= TS_MON;
      ts_cnt                     <= '1; // first window runs full
      temp_bias_window           <= 1'b0;
      temp_sense_control_pin_out <= 1'b0;
      temp_sense_control_pin_oe  <= 1'b0;
    end else begin
      ts_state <= next_ts;
      ts_cnt   <= (bias_end || mon_end) ? '0 : ts_cnt + 1'b1;
      temp_bias_window           <= (next_ts == TS_BIAS);
      temp_sense_control_pin_out <= 1'b1;
      temp_sense_control_pin_oe  <= (next_ts == TS_BIAS);
    end
  end

  // one deglitch filter each for hot and cold, live only in the window
  genvar ch;
  generate
    for (ch = 0; ch < `WRC_TS_CH; ch++) begin : g_degl
      wrc_deglitch #(
        .CYC (DEGL_CYC)
      ) u_degl (
        .clk       (clk),
        .rst       (rst),
        .sample_en (ts_state == TS_BIAS),
        .raw       (ts_raw[ch]),
        .level     (ts_degl[ch])
      );
    end
  endgenerate

  // fault re-judged at every window end; a detection inside
  // the window takes effect at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_fault <= 1'b0;
      host_seen  <= 1'b0;
      host_ctrl  <= 1'b0;
    end else begin
      temp_fault <= bias_end ? |ts_degl
                             : (temp_fault || |ts_degl);
      host_seen  <= bias_end ? 1'b0 : (host_seen || mon_hit);
      host_ctrl  <= mon_end ? (host_seen || mon_hit)
                            : (host_ctrl || mon_hit);
    end
  end

  // helper counters for long intervals
  logic [`WRC_CNT_W-1:0] gap_cnt;
  logic                  gap_run;
  logic [`WRC_CNT_W-1:0] bias_len;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_cnt  <= '0;
      gap_run  <= 1'b0;
      bias_len <= '0;
    end else begin
      gap_cnt  <= bit_take ? '0 : gap_cnt + 1'b1;
      gap_run  <= bit_take ? 1'b1 : (gap_run && bp_active);
      bias_len <= temp_bias_window ? bias_len + 1'b1 : '0;
    end
  end

  chk_pg_follows_supply: assert property (
    @(posedge clk) disable iff (rst)
    power_good_oe == supply_en && !power_good_n_out)
    else $error("power-good pin not tracking supply enable");

  chk_supply_needs_conv: assert property (
    @(posedge clk) disable iff (rst)
    $rose(supply_en) |-> $past(conv_s) && $past(uvlo_s))
    else $error("supply enabled before convergence");

  chk_bit_period_len: assert property (
    @(posedge clk) disable iff (rst)
    bit_take && gap_run |-> gap_cnt == 2 * HALF_CYC - 1'b1)
    else $error("bit period length wrong");

  chk_biphase_mid: assert property (
    @(posedge clk) disable iff (rst)
    bp_mid |=> (bp_mod != $past(bp_mod)) == $past(bp_bit))
    else $error("mid-bit transition does not match bit value");

  chk_biphase_edge: assert property (
    @(posedge clk) disable iff (rst)
    bit_take |=> bp_mod != $past(bp_mod) ##1
    comm_switch_a == $past(bp_mod))
    else $error("missing transition at bit boundary");

  chk_char_frame: assert property (
    @(posedge clk) disable iff (rst)
    load |=> shreg[0] == `WRC_START_BIT
    && shreg[`WRC_CHAR_BITS-1] == `WRC_STOP_BIT
    && shreg[`WRC_DATA_BITS:1] == $past(tx_byte)
    && ^shreg[`WRC_DATA_BITS+1:1])
    else $error("character frame malformed");

  chk_char_bits: assert property (
    @(posedge clk) disable iff (rst)
    load |=> bits_left == `WRC_CHAR_BITS && !tx_ready)
    else $error("character does not hold eleven bits");

  chk_switch_pair: assert property (
    @(posedge clk) disable iff (rst)
    comm_switch_a == comm_switch_b)
    else $error("communication switches disagree");

  chk_idle_open: assert property (
    @(posedge clk) disable iff (rst)
    !bp_active && !bit_take |=> !comm_switch_a ##1 !comm_switch_a)
    else $error("switch closed with nothing to send");

  chk_ilim_value: assert property (
    @(posedge clk) disable iff (rst)
    ##1 comm_ilim_ma == (($past(iout_ma) > `WRC_ILIM_KNEE_MA)
      ? {1'b0, $past(iout_ma)} + `WRC_ILIM_ADD_MA
      : `WRC_ILIM_FIX_MA))
    else $error("communication current limit wrong");

  chk_rect_lockout: assert property (
    @(posedge clk) disable iff (rst)
    !uvlo_s |=> rect_mode == RECT_DIODE)
    else $error("synchronous rectifier on below lockout");

  chk_rect_rise: assert property (
    @(posedge clk) disable iff (rst)
    rect_mode == RECT_HALF && uvlo_s && iout_ma > `WRC_RECT_UP_MA
    |=> rect_mode == RECT_FULL)
    else $error("full synchronous mode not entered");

  chk_rect_hold: assert property (
    @(posedge clk) disable iff (rst)
    rect_mode == RECT_FULL && uvlo_s
    |=> rect_mode == ($past(iout_ma) < `WRC_RECT_DN_MA
                      ? RECT_HALF : RECT_FULL))
    else $error("full synchronous hysteresis broken");

  chk_bias_len: assert property (
    @(posedge clk) disable iff (rst)
    $fell(temp_bias_window) |-> $past(bias_len) == BIAS_CYC - 1'b1)
    else $error("bias window length wrong");

  chk_bias_float: assert property (
    @(posedge clk) disable iff (rst)
    temp_sense_control_pin_oe == temp_bias_window)
    else $error("bias pin driven outside window");

  chk_host_flag: assert property (
    @(posedge clk) disable iff (rst)
    mon_hit |=> host_ctrl ##1 host_ctrl)
    else $error("host drive not flagged");

  chk_err_pulse: assert property (
    @(posedge clk) disable iff (rst)
    err_pkt_due |-> !$past(err_pkt_due) && $past(uvlo_s))
    else $error("error packet cadence broken");

  cov_char_sent: cover property (
    @(posedge clk) disable iff (rst) load ##1 bit_take);
  cov_rect_full: cover property (
    @(posedge clk) disable iff (rst) rect_mode == RECT_FULL);
  cov_host_seen: cover property (
    @(posedge clk) disable iff (rst) $rose(host_ctrl));
  cov_temp_fault: cover property (
    @(posedge clk) disable iff (rst) $rose(temp_fault));
endmodule

//--- test/wrc_tx_demod.sv
// transmitter side: recovers characters from the coil loading
module wrc_tx_demod #(
  parameter int H = 8
) (
  // clock and coil loading
  input  wire logic  clk,
  input  wire logic  coil_load,
  // recovered stream
  output logic [31:0] rx_log,
  output int          n_bytes,
  output int          n_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] sh;
  logic        lv, a, b;
  int          n;
  // sample each half bit; a missing boundary edge means idle
  initial begin
    rx_log = 32'h0;
    n_bytes = 0;
    n_bad = 0;
    lv = 1'b0;
    n = 0;
    sh = 11'h0;
    forever begin
      @(negedge clk);
      if (coil_load === lv) begin
        n = 0;  // no edge at a boundary drops a partial frame
      end else begin
        repeat (H / 2) @(negedge clk);
        a = coil_load;
        repeat (H) @(negedge clk);
        b = coil_load;
        repeat (H / 2 - 1) @(negedge clk);
        lv = b;
        sh = {a !== b, sh[10:1]};
        n++;
        if (n == 11) begin
          n = 0;
          n_bytes++;
          rx_log = {rx_log[23:0], sh[8:1]};
          if (sh[0] || !sh[10] || !(^sh[9:1])) n_bad++;
        end
      end
    end
  end
endmodule

//--- test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wrc_pkg::*;
  // shortened counts keep the run brief
  localparam int H = 8, BIAS = 64, DEGL = 16, MONP = 40, MONS = 80;
  localparam int ERRF = 100, ERRS = 200;
  localparam logic [11:0] IV [6] = '{12'h79, 12'h6e, 12'h63, 12'h12c,
                                     12'h12d, 12'h3e8};
  localparam logic [2:0] RX [6] = '{RECT_FULL, RECT_FULL, RECT_HALF,
                                    RECT_FULL, RECT_FULL, RECT_FULL};
  localparam logic [12:0] LI [6] = '{13'h190, 13'h190, 13'h190,
                                     13'h190, 13'h15f, 13'h41a};
  localparam logic [7:0] TXB [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c};
  logic        clk = 1'b0;
  logic        rst, uvlo, conv, hot, cold, ts_hi, tx_valid, tx_ready;
  logic        sw_a, sw_b, sup, pg_n, pg_oe, err_due, win, ts_out, ts_oe;
  logic        tfault, host;
  logic [11:0] iout;
  logic [7:0]  tx_byte;
  logic [12:0] ilim;
  wrc_rect_t   rect;
  logic [31:0] rx_log;
  int          n_bytes, n_bad, x, n;
  int          errors = 0, checked = 0, ab_diff = 0;
  wire  [1:0]  mon = {win, err_due};

  always #20 clk = ~clk;

  wrc_top #(
    .HALF_CYC(24'(H)), .BIAS_CYC(24'(BIAS)), .DEGL_CYC(24'(DEGL)),
    .MON_PRI_CYC(24'(MONP)), .MON_STD_CYC(24'(MONS)),
    .ERR_FAST_CYC(24'(ERRF)), .ERR_SLOW_CYC(24'(ERRS))
  ) dut (
    .clk(clk), .rst(rst), .rectified_voltage_above_uvlo(uvlo), .rectified_voltage_converged(conv),
    .iout_ma(iout), .ts_hot(hot), .ts_cold(cold), .ts_above_100mv(ts_hi),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .comm_switch_a(sw_a), .comm_switch_b(sw_b), .supply_en(sup),
    .power_good_n_out(pg_n), .power_good_oe(pg_oe), .comm_ilim_ma(ilim),
    .rect_mode(rect), .err_pkt_due(err_due), .temp_bias_window(win),
    .temp_sense_control_pin_out(ts_out), .temp_sense_control_pin_oe(ts_oe),
    .temp_fault(tfault), .host_ctrl(host)
  );

  wrc_tx_demod #(.H(H)) rx (
    .clk(clk), .coil_load(sw_a), .rx_log(rx_log), .n_bytes(n_bytes),
    .n_bad(n_bad)
  );

  // the two switches must never disagree
  always @(negedge clk) begin
    if (sw_a !== sw_b) ab_diff++;
  end

  task automatic step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // wait for a level, then count how long it lasts
  task automatic span(input int i, input logic lv, output int len);
    int k;
    k = 0;
    len = 0;
    while (mon[i] !== lv && k < 3000) begin
      step();
      k++;
    end
    while (mon[i] === lv && len < 3000) begin
      step();
      len++;
    end
  endtask

  // valid stays up between bytes so no edge sees it pulse
  task automatic send(input logic [7:0] b);
    int k;
    tx_byte = b;
    tx_valid = 1'b1;
    k = 0;
    while (tx_ready !== 1'b1 && k < 1000) begin
      step();
      k++;
    end
    step();
  endtask

  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1; uvlo = 1'b0; conv = 1'b0; hot = 1'b0; cold = 1'b0;
    ts_hi = 1'b0; tx_valid = 1'b0; tx_byte = 8'h00; iout = 12'h000;
    step(2);
    cmp(ilim, 32'h190);
    cmp({sup, pg_oe, sw_a}, 32'h0);
    step();
    rst = 1'b0;
    step(5);
    cmp(rect, RECT_DIODE);
    uvlo = 1'b1;
    step(4);
    cmp(rect, RECT_HALF);
    for (int i = 0; i < 6; i++) begin
      iout = IV[i];
      step(2);
      cmp(rect, RX[i]);
      cmp(ilim, LI[i]);
    end
    iout = 12'h000;
    step(20);
    cmp({sup, pg_oe}, 32'h0);
    span(0, 1'b1, x);
    span(0, 1'b0, n);
    cmp(n, ERRF - 1);
    span(1, 1'b0, x);
    cmp({ts_oe, ts_out}, 32'h3);
    span(1, 1'b1, n);
    cmp(n, BIAS);
    cmp(ts_oe, 32'h0);
    span(1, 1'b0, n);
    cmp(n, MONP);
    conv = 1'b1;
    step(5);
    cmp({sup, pg_oe, pg_n}, 32'h6);
    span(0, 1'b1, x);
    span(0, 1'b0, n);
    cmp(n, ERRS - 1);
    span(1, 1'b1, x);
    span(1, 1'b0, n);
    cmp(n, MONS);
    cmp(sw_a, 32'h0);
    for (int i = 0; i < 4; i++) send(TXB[i]);
    tx_valid = 1'b0;
    for (int k = 0; k < 2000 && n_bytes < 4; k++) step();
    step(2 * H + 4);
    cmp(rx_log, 32'h00ffa53c);
    cmp(n_bad, 32'h0);
    cmp(ab_diff, 32'h0);
    cmp(sw_a, 32'h0);
    // a glitch shorter than the deglitch must be ignored
    span(1, 1'b0, x);
    cold = 1'b1;
    step(DEGL - 6);
    cold = 1'b0;
    span(1, 1'b1, n);
    step(2);
    cmp(tfault, 32'h0);
    span(1, 1'b0, x);
    hot = 1'b1;
    span(1, 1'b1, n);
    step(2);
    cmp({tfault, sup}, 32'h2);
    hot = 1'b0;
    ts_hi = 1'b1;
    step(4);
    cmp(host, 32'h1);
    ts_hi = 1'b0;
    final_report();
  end

  // watchdog: the sequence needs well under 6000 cycles
  initial begin
    step(30000);
    errors++;
    final_report();
  end
endmodule
